// ==== src/splitter_defs.vh ====
// register offsets, field positions and reset values for the splitter control bank
`ifndef SPLITTER_DEFS_VH
`define SPLITTER_DEFS_VH
`define OFS_CONTROL      3'h0
`define OFS_RECEIVER     3'h1
`define OFS_PORT1_OUT    3'h2
`define OFS_PORT2_OUT    3'h3
`define OFS_PORT3_OUT    3'h4
`define RST_CONTROL      8'hFF
`define RST_RECEIVER     8'h00
`define RST_PORT_OUT     8'h00
`define CTL_NORMAL_BIT   7
`define CTL_P1_EN_BIT    6
`define CTL_P2_EN_BIT    5
`define CTL_P3_EN_BIT    4
`define CTL_P4_EN_BIT    3
`define CTL_DETECT_BIT   2
`define RX_TERM_OFF_BIT  7
`define RX_BIAS_BIT      6
`define RX_BIAS_REG_BIT  5
`define RX_EQ_MSB        4
`define RX_EQ_LSB        2
`define RX_SQ_OFF_BIT    1
`define TX_TYPE_BIT      7
`define TX_EMPH_MSB      6
`define TX_EMPH_LSB      4
`define TX_SWING_MSB     3
`define TX_SWING_LSB     2
`define TX_SLEW_MSB      1
`define TX_SLEW_LSB      0
`endif

// ==== src/port_output_decode.v ====
// decodes one port transmitter setup byte into driver controls
`include "splitter_defs.vh"
module port_output_decode (
  // setup byte
  input  wire [7:0] setup,
  // decoded driver controls
  output reg        double_term,
  output reg  [2:0] emph_level,
  output reg        emph_high_swing,
  output reg  [1:0] swing_trim,
  output reg  [1:0] slew_trim
);
  // emph_level 0..4 = 0, 1.5, 2.5, 3.5, 6 dB; swing 0..3 = nom,-10,+10,+20%; slew 0..2 = nom,+5,+10%
  always @* begin
    double_term = setup[`TX_TYPE_BIT];
    emph_high_swing = setup[`TX_EMPH_MSB];
    if (setup[`TX_EMPH_MSB]) begin
      emph_level = 3'h4;
    end else begin
      emph_level = {1'b0, setup[`TX_EMPH_MSB-1:`TX_EMPH_LSB]};
    end
    swing_trim = setup[`TX_SWING_MSB:`TX_SWING_LSB];
    case (setup[`TX_SLEW_MSB:`TX_SLEW_LSB])
      2'h0: slew_trim = 2'h0;
      2'h3: slew_trim = 2'h2;
      default: slew_trim = 2'h1;
    endcase
  end
endmodule

// ==== src/splitter_control_registers.v ====
// control register bank of the 1:4 splitter, with derived analog controls
`include "splitter_defs.vh"
module splitter_control_registers (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // register access port (from the serial slave front end)
  input  wire       reg_wr,
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // device pins
  input  wire       control_source_select,
  input  wire       output_enable_pin,
  input  wire       all_ports_pin,
  input  wire [1:0] port_select_pin,
  input  wire       bias_pin,
  input  wire [3:0] sink_plug_detect,
  input  wire       clock_detected,
  output reg        source_plug_indicator,
  // receiver controls
  output reg        rx_powered,
  output reg        rx_term_connected,
  output reg        rx_bias_to_supply,
  output reg  [2:0] rx_eq_code,
  output reg  [5:0] rx_eq_halfdb,
  output reg        squelch_active,
  // driver controls per port
  output reg  [3:0] port_active,
  output reg  [2:0] port_double_term,
  output reg  [8:0] port_emph_level,
  output reg  [2:0] port_emph_high_swing,
  output reg  [5:0] port_swing_trim,
  output reg  [5:0] port_slew_trim
);
  // register storage
  reg  [7:0] control_reg;
  reg  [7:0] receiver_reg;
  reg  [7:0] port_setup_reg [0:2];
  // pin synchronisers, two flops before any logic
  reg  [9:0] pin_meta_reg;
  reg  [9:0] pin_sync_reg;
  wire       mode_reg_s;
  wire       oe_s;
  wire       all_s;
  wire [1:0] sel_s;
  wire       bias_s;
  wire [3:0] plug_s;
  wire       clk_det_s;
  // combinational next values
  reg  [3:0] port_enable_next;
  reg  [3:0] port_active_next;
  reg        term_next;
  reg        bias_next;
  reg  [5:0] eq_next;
  reg        plug_next;
  reg  [7:0] rdata_next;
  // global qualifiers
  wire       detect_on;
  wire       squelch_on;
  // decoder outputs, packed per port
  wire [2:0] dt_w;
  wire [8:0] em_w;
  wire [2:0] hs_w;
  wire [5:0] sw_w;
  wire [5:0] sl_w;

  // synchronise asynchronous pin levels; a pin change reaches the outputs
  // three edges later: two synchroniser flops, then the output flop
  // levels only: a pin pulse shorter than a clock may be lost, which
  // straps and plug-detect lines tolerate
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 10'h000;
      pin_sync_reg <= 10'h000;
    end else begin
      pin_meta_reg <= {clock_detected, sink_plug_detect, bias_pin, port_select_pin,
                       all_ports_pin, output_enable_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign oe_s       = pin_sync_reg[0];
  assign all_s      = pin_sync_reg[1];
  assign sel_s      = pin_sync_reg[3:2];
  assign bias_s     = pin_sync_reg[4];
  assign plug_s     = pin_sync_reg[8:5];
  assign clk_det_s  = pin_sync_reg[9];

  // mode select is a strap-like pin, synchronised separately
  reg mode_meta_reg;
  reg mode_sync_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
    end else begin
      mode_meta_reg <= control_source_select;
      mode_sync_reg <= mode_meta_reg;
    end
  end
  assign mode_reg_s = mode_sync_reg;

  // register writes; reserved bits kept as plain storage
  // unmapped offsets drop the write, so no access has side effects
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg       <= `RST_CONTROL;
      receiver_reg      <= `RST_RECEIVER;
      port_setup_reg[0] <= `RST_PORT_OUT;
      port_setup_reg[1] <= `RST_PORT_OUT;
      port_setup_reg[2] <= `RST_PORT_OUT;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_CONTROL:   control_reg       <= reg_wdata;
        `OFS_RECEIVER:  receiver_reg      <= reg_wdata;
        `OFS_PORT1_OUT: port_setup_reg[0] <= reg_wdata;
        `OFS_PORT2_OUT: port_setup_reg[1] <= reg_wdata;
        `OFS_PORT3_OUT: port_setup_reg[2] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // per-port setup decode; port 4 has no setup register here
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_port
      port_output_decode u_dec (
        .setup           (port_setup_reg[gi]),
        .double_term     (dt_w[gi]),
        .emph_level      (em_w[3*gi+2:3*gi]),
        .emph_high_swing (hs_w[gi]),
        .swing_trim      (sw_w[2*gi+1:2*gi]),
        .slew_trim       (sl_w[2*gi+1:2*gi])
      );
    end
  endgenerate

  // detection control comes up enabled with the control reset value
  assign detect_on  = control_reg[`CTL_DETECT_BIT];
  // squelch engages when enabled and no input clock is seen
  assign squelch_on = ~receiver_reg[`RX_SQ_OFF_BIT] & ~clk_det_s;

  // port enable source: register bits in register mode, straps otherwise
  always @* begin
    if (mode_reg_s) begin
      // register bits only govern while the mode pin selects register control
      port_enable_next = {control_reg[`CTL_P4_EN_BIT],
                          control_reg[`CTL_P3_EN_BIT],
                          control_reg[`CTL_P2_EN_BIT],
                          control_reg[`CTL_P1_EN_BIT]};
    end else if (all_s) begin
      port_enable_next = 4'hF;
    end else begin
      // one-hot strap decode, select 0 is port 1
      port_enable_next = 4'h1 << sel_s;
    end
  end

  // port activity: enable, then plug gating, then the global kills
  always @* begin
    port_active_next = port_enable_next;
    if (detect_on) begin
      // a port with nothing plugged stays dark even when enabled
      port_active_next = port_active_next & plug_s;
    end
    if (!oe_s || !control_reg[`CTL_NORMAL_BIT]) begin
      // enable pin low or standby: every driver is powered down
      port_active_next = 4'h0;
    end
    if (squelch_on) begin
      // no input clock: drivers off rather than pass noise downstream
      port_active_next = 4'h0;
    end
  end

  // input termination: register bit, then detection and enable pin overrides
  always @* begin
    term_next = ~receiver_reg[`RX_TERM_OFF_BIT];
    if (detect_on && plug_s == 4'h0) begin
      // nothing plugged anywhere, so the input need not load the source
      term_next = 1'b0;
    end
    if (!oe_s) begin
      // enable pin low shuts the receiver, its termination with it
      term_next = 1'b0;
    end
  end

  // termination bias: the register choice only once bit 5 hands it over
  always @* begin
    if (receiver_reg[`RX_BIAS_REG_BIT]) begin
      bias_next = receiver_reg[`RX_BIAS_BIT];
    end else begin
      // default: the bias strap alone decides
      bias_next = bias_s;
    end
  end

  // equalizer gain in half-dB units, so 2.5 dB steps stay whole numbers;
  // a table rather than arithmetic keeps code 101 on the step line
  always @* begin
    case (receiver_reg[`RX_EQ_MSB:`RX_EQ_LSB])
      3'h0: eq_next = 6'h05;
      3'h1: eq_next = 6'h0A;
      3'h2: eq_next = 6'h0F;
      3'h3: eq_next = 6'h14;
      3'h4: eq_next = 6'h19;
      3'h5: eq_next = 6'h1E;
      3'h6: eq_next = 6'h23;
      3'h7: eq_next = 6'h28;
      default: eq_next = 6'h05;
    endcase
  end

  // source plug indicator: plugged ports among the enabled ones
  always @* begin
    // one expression serves both modes: port_enable_next already holds the register bits or the straps
    plug_next = |(plug_s & port_enable_next);
    if (!oe_s) begin
      // enable pin low reports nothing plugged to the source
      plug_next = 1'b0;
    end
  end

  // read mux; the result is registered below, one cycle after the address
  always @* begin
    case (reg_addr)
      `OFS_CONTROL:   rdata_next = control_reg;
      `OFS_RECEIVER:  rdata_next = receiver_reg;
      `OFS_PORT1_OUT: rdata_next = port_setup_reg[0];
      `OFS_PORT2_OUT: rdata_next = port_setup_reg[1];
      `OFS_PORT3_OUT: rdata_next = port_setup_reg[2];
      default:        rdata_next = 8'h00;
    endcase
  end

  // all outputs registered so analog controls never glitch
  // one cycle of lag on every control is the price of glitch-free levels
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // read path and plug indicator
      reg_rdata             <= 8'h00;
      source_plug_indicator <= 1'b0;
      // receiver controls
      rx_powered            <= 1'b0;
      rx_term_connected     <= 1'b0;
      rx_bias_to_supply     <= 1'b0;
      rx_eq_code            <= 3'h0;
      rx_eq_halfdb          <= 6'h05;
      squelch_active        <= 1'b0;
      // driver controls
      port_active           <= 4'h0;
      port_double_term      <= 3'h0;
      port_emph_level       <= 9'h000;
      port_emph_high_swing  <= 3'h0;
      port_swing_trim       <= 6'h00;
      port_slew_trim        <= 6'h00;
    end else begin
      // read path and plug indicator
      reg_rdata             <= rdata_next;
      source_plug_indicator <= plug_next;
      // receiver controls
      rx_powered            <= oe_s & control_reg[`CTL_NORMAL_BIT];
      rx_term_connected     <= term_next;
      rx_bias_to_supply     <= bias_next;
      rx_eq_code            <= receiver_reg[`RX_EQ_MSB:`RX_EQ_LSB];
      rx_eq_halfdb          <= eq_next;
      squelch_active        <= squelch_on;
      // driver controls
      port_active           <= port_active_next;
      port_double_term      <= dt_w;
      port_emph_level       <= em_w;
      port_emph_high_swing  <= hs_w;
      port_swing_trim       <= sw_w;
      port_slew_trim        <= sl_w;
    end
  end
endmodule

// ==== tb/splitter_props.sv ====
// assertions on the splitter control bank ports
module splitter_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // register port
  input wire logic       reg_wr,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // enable pin and observed controls
  input wire logic       output_enable_pin,
  input wire logic       rx_powered,
  input wire logic       rx_term_connected,
  input wire logic       source_plug_indicator,
  input wire logic [2:0] rx_eq_code,
  input wire logic [5:0] rx_eq_halfdb,
  input wire logic       squelch_active,
  input wire logic [3:0] port_active,
  input wire logic [8:0] port_emph_level,
  input wire logic [2:0] port_emph_high_swing,
  input wire logic [5:0] port_slew_trim
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // pins land three edges late: two sync flops plus the output flop
  a_oe_low: assert property (!$past(output_enable_pin, 3) |->
    !rx_powered && !rx_term_connected && port_active == 4'h0 && !source_plug_indicator)
    else $error("outputs live with enable pin low");
  a_squelch_off: assert property (squelch_active |-> port_active == 4'h0)
    else $error("port active in squelch");
  a_eq_steps: assert property (
    rx_eq_halfdb == ({3'h0, rx_eq_code} + 6'h01) * 6'h05)
    else $error("gain off step table");
  a_eq_cause: assert property (
    $changed(rx_eq_code) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 3'h1)
    else $error("gain moved without write");
  a_emph_swing: assert property (port_emph_high_swing ==
    {port_emph_level[8:6] == 3'h4, port_emph_level[5:3] == 3'h4, port_emph_level[2:0] == 3'h4})
    else $error("swing flag mismatch");
  a_slew_codes: assert property (port_slew_trim[1:0] != 2'h3 &&
    port_slew_trim[3:2] != 2'h3 && port_slew_trim[5:4] != 2'h3)
    else $error("slew trim out of range");
  a_write_back: assert property (reg_wr && reg_addr < 3'h5 ##1
    !reg_wr && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read back differs");
  a_unmapped_zero: assert property (reg_addr > 3'h4 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  c_squelch: cover property (squelch_active);
  c_eq_top: cover property (rx_eq_code == 3'h7);
  c_refused: cover property (reg_wr && reg_addr > 3'h4);
endmodule

bind splitter_control_registers splitter_props chk (.*);

// ==== tb/reg_host.sv ====
// host model: one byte per access on the bank's register port
module reg_host (
  // clock
  input  wire logic       clk,
  // register port of the bank
  output      logic       reg_wr,
  output      logic [2:0] reg_addr,
  output      logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {reg_wr, reg_addr, reg_wdata} = 12'h000;
  // strobe for one edge; data inverted after so no stale byte lingers
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask
endmodule

// ==== tb/tb_splitter_control_registers.sv ====
// testbench for the splitter control bank
module tb_splitter_control_registers;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr, control_source_select, output_enable_pin, all_ports_pin, bias_pin;
  logic        clock_detected, source_plug_indicator, rx_powered, rx_term_connected;
  logic        rx_bias_to_supply, squelch_active;
  logic [1:0]  port_select_pin;
  logic [2:0]  reg_addr, rx_eq_code, port_double_term, port_emph_high_swing;
  logic [3:0]  sink_plug_detect, port_active;
  logic [5:0]  rx_eq_halfdb;
  logic [5:0]  port_swing_trim, port_slew_trim;
  logic [7:0]  reg_wdata, reg_rdata, ctl, rx, d;
  logic [8:0]  port_emph_level;
  logic [23:0] tx;
  logic [31:0] seed = 32'h31, r;
  int          bad_count = 0;
  int          num_checks = 0;

  splitter_control_registers uut (.*);
  reg_host host (.*);

  always #5 clk = ~clk;

  // xorshift source with a fixed start, so every run repeats
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] slew(input logic [1:0] c);
    return c == 2'h3 ? 2'h2 : {1'b0, c != 2'h0};
  endfunction
  // shadow of the bank; unmapped offsets read zero
  function automatic logic [7:0] exp_rd(input int a);
    logic [39:0] m;
    m = {tx, rx, ctl};
    return a < 5 ? m[8*a +: 8] : 8'h00;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // pin-mode reads skip register-only outputs, whose meaning there is open
  task automatic cmp_all();
    logic [3:0] en;
    logic       sq, t;
    logic [7:0] s;
    en = control_source_select ? {ctl[3], ctl[4], ctl[5], ctl[6]} :
         all_ports_pin ? 4'hF : 4'h1 << port_select_pin;
    sq = !rx[1] && !clock_detected;
    t = ctl[2] && sink_plug_detect == 4'h0;
    chk(rx_powered, output_enable_pin && ctl[7]);
    chk(source_plug_indicator, output_enable_pin && |(en & sink_plug_detect));
    en = en & (ctl[2] ? sink_plug_detect : 4'hF) & {4{output_enable_pin && !sq && ctl[7]}};
    chk(port_active, en);
    chk(squelch_active, sq);
    if (!control_source_select) return;
    chk(rx_term_connected, output_enable_pin && !rx[7] && !t);
    chk(rx_bias_to_supply, rx[5] ? rx[6] : bias_pin);
    chk(rx_eq_code, rx[4:2]);
    chk(rx_eq_halfdb, (rx[4:2] + 16'h1) * 16'h5);
    for (int i = 0; i < 3; i++) begin
      s = tx[8*i +: 8];
      chk({port_double_term[i], port_emph_high_swing[i]}, s[7:6]);
      chk(port_emph_level[3*i +: 3], s[6] ? 3'h4 : {1'b0, s[5:4]});
      chk(port_swing_trim[2*i +: 2], s[3:2]);
      chk(port_slew_trim[2*i +: 2], slew(s[1:0]));
    end
  endtask

  // hang guard, far past the nine hundred or so cycles needed
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end

  // reset values, then random settings with fixed corners mixed in
  initial begin
    {control_source_select, output_enable_pin, clock_detected} = 3'h7;
    {all_ports_pin, bias_pin, port_select_pin, sink_plug_detect} = 8'h0F;
    {ctl, rx, tx} = {8'hFF, 32'h0};
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 cmp_all();
    for (int a = 0; a < 8; a++) begin
      host.rd(3'(a), d);
      chk(d, exp_rd(a));
    end
    for (int i = 0; i < 48; i++) begin
      ctl = 8'(rnd());
      {rx, tx} = rnd();
      r = rnd();
      // corners: every gain code in register mode; nothing plugged with a live input
      if (i < 8) rx[4:2] = 3'(i);
      if (i == 1) rx[7] = 1'b0;
      ctl[7] = ctl[7] | r[14];
      ctl[2] = ctl[2] | (i == 1);
      {all_ports_pin, bias_pin, port_select_pin, sink_plug_detect} = r[7:0];
      control_source_select = |r[9:8] || i < 8;
      output_enable_pin = |r[11:10] || i == 1;
      clock_detected = |r[13:12];
      if (i == 1) sink_plug_detect = 4'h0;
      if (!control_source_select) sink_plug_detect = 4'hF;
      for (int a = 0; a < 6; a++) host.wr(3'(a), a < 5 ? exp_rd(a) : r[31:24]);
      repeat (4) @(posedge clk);
      #1 cmp_all();
      host.rd(r[18:16], d);
      chk(d, exp_rd(r[18:16]));
    end
    tally_and_finish();
  end
endmodule
